/* rtl/meb_port.sv */
`timescale 1ns/10ps
// Overview of operation
// - Bus clock runs free, or gives one low-high pulse per access, stretched.
// - Bus clock behaviour set by clock-disable, visibility and stretch bits.
// - Low-byte strobe is low when the low data lane carries valid data.
// - In peripheral mode the strobe pin is an input giving transfer size.
// - In wide or emulation narrow modes, strobe low at clock fall tags low half.
// - Read/write direction is driven out, but is an input in peripheral mode.
// - Port E bit 1 is input only and readable even with interrupt enabled.
// - Maskable interrupt is level or edge sensitive; bit 0 is non-maskable input.
// - Port K bits 6 and 7 may act as data and emulation chip selects.
// - Port A data, port B data, port A direction at offsets 0, 1, 2.
// - Port E data, direction and assignment at offsets 8, 9, 0xA.
// - Pull control, reduced drive and bus control at offsets 0xC, 0xD, 0xE.
// - Interrupt control at 0x1E, port K data and direction at 0x32, 0x33.
// - The block base address is relocatable.
// - Mode pin levels are captured into the mode bits on the third clock after reset ends.
// - Port reads give pin level for input bits, data register for output bits.
// - Unused registers read as zero.
module meb_port (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    input  wire logic [9:0]  blockBase,
    input  wire logic [2:0]  modePins,
    input  wire logic        busReq,
    input  wire logic        busWrite,
    input  wire logic        busWide,
    input  wire logic        busSlow,
    input  wire logic [15:0] busAddr,
    input  wire logic [15:0] busWdata,
    output logic      [15:0] busRdata,
    output logic             busDone,
    input  wire logic        tagOn,
    input  wire logic        xcsHit,
    input  wire logic        ecsHit,
    input  wire logic [5:0]  expAddrHi,
    input  wire logic        irqAck,
    output logic             irqReq,
    output logic             nmiReqN,
    output logic             lowTagN,
    output logic             xferSize8,
    output logic             extWriteN,
    input  wire logic [7:0]  paIn,
    output logic      [7:0]  paOut,
    output logic      [7:0]  paOeN,
    input  wire logic [7:0]  pbIn,
    output logic      [7:0]  pbOut,
    output logic      [7:0]  pbOeN,
    input  wire logic [7:0]  peIn,
    output logic      [7:0]  peOut,
    output logic      [7:0]  peOeN,
    input  wire logic [7:0]  pkIn,
    output logic      [7:0]  pkOut,
    output logic      [7:0]  pkOeN
);
    logic [7:0] paData_reg, pbData_reg, paDir_reg, pbDir_reg;
    logic [7:0] peData_reg, peDir_reg, port_e_pin_assignment_reg, mode_reg;
    logic [7:0] pull_reg, rdrive_reg, busCtl_reg, irqCtl_reg;
    logic [7:0] pkData_reg, pkDir_reg;
    logic [7:0] paS1, paSync, pbS1, pbSync, peS1, peSync, pkS1, pkSync;
    logic [2:0] modeS1, modeSync;
    logic [1:0] capCnt_reg;
    logic       capDone_reg;
    logic       hit, wr, periph, expanded, tagMode;
    logic [5:0] off;
    meb_pkg::meb_state_t state_reg;
    logic [3:0] stretch_reg;
    logic       reqWrite_reg, reqLow_reg;
    logic [15:0] reqAddr_reg, reqWdata_reg;
    logic       eclkNext, irqPin1_reg;

    assign off      = regAddr[meb_pkg::OFF_WIDTH-1:0];
    assign hit      = (regAddr[15:meb_pkg::OFF_WIDTH] == blockBase);
    assign wr       = regWr && hit;
    assign periph   = (mode_reg[7:5] == meb_pkg::MD_PERIPH);
    assign expanded = mode_reg[meb_pkg::MODE_FLD_LO];
    assign tagMode  = (mode_reg[7:5] == meb_pkg::MD_EMU_WIDE)
                   || (mode_reg[7:5] == meb_pkg::MD_NORM_WIDE)
                   || (mode_reg[7:5] == meb_pkg::MD_EMU_NARROW);

    // Two-stage synchronisers for every pin input.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {paS1, paSync, pbS1, pbSync} <= '0;
            {peS1, peSync, pkS1, pkSync} <= {16'h0303, 16'h0000};
            {modeS1, modeSync} <= '0;
        end else begin
            paS1 <= paIn;
            paSync <= paS1;
            pbS1 <= pbIn;
            pbSync <= pbS1;
            peS1 <= peIn;
            peSync <= peS1;
            pkS1 <= pkIn;
            pkSync <= pkS1;
            modeS1 <= modePins;
            modeSync <= modeS1;
        end
    end

    // Register writes; reserved offsets fall through the case untouched.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {paData_reg, pbData_reg, paDir_reg, pbDir_reg} <= {4{meb_pkg::RST_BYTE}};
            {peData_reg, peDir_reg, port_e_pin_assignment_reg} <= {3{meb_pkg::RST_BYTE}};
            {pull_reg, rdrive_reg, busCtl_reg} <= {3{meb_pkg::RST_BYTE}};
            {pkData_reg, pkDir_reg} <= {2{meb_pkg::RST_BYTE}};
            irqCtl_reg <= meb_pkg::RST_INTERRUPT_PIN_CONTROL;
        end else if (wr) begin
            case (off)
                meb_pkg::OFF_PA_DATA:   paData_reg <= regWdata;
                meb_pkg::OFF_PB_DATA:   pbData_reg <= regWdata;
                meb_pkg::OFF_PA_DIR:    paDir_reg <= regWdata;
                meb_pkg::OFF_PB_DIR:    pbDir_reg <= regWdata;
                meb_pkg::OFF_PE_DATA:   peData_reg <= regWdata;
                meb_pkg::OFF_PE_DIR:    peDir_reg <= regWdata;
                meb_pkg::OFF_PE_ASSIGN: port_e_pin_assignment_reg <= regWdata;
                meb_pkg::OFF_PULL:      pull_reg <= regWdata;
                meb_pkg::OFF_RDRIVE:    rdrive_reg <= regWdata;
                meb_pkg::OFF_BUS_CTL:   busCtl_reg <= regWdata;
                meb_pkg::OFF_IRQ_CTL:   irqCtl_reg <= regWdata;
                meb_pkg::OFF_PK_DATA:   pkData_reg <= regWdata;
                meb_pkg::OFF_PK_DIR:    pkDir_reg <= regWdata;
                default: ;
            endcase
        end
    end

    // The pins are only stable after both synchroniser stages have filled,
    // so the mode capture waits that long after reset is released.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_reg <= meb_pkg::RST_BYTE;
            capCnt_reg <= 2'h0;
            capDone_reg <= 1'b0;
        end else if (!capDone_reg) begin
            capCnt_reg <= capCnt_reg + 2'h1;
            if (capCnt_reg == meb_pkg::MODE_CAP_WAIT) begin
                mode_reg[7:5] <= modeSync;
                capDone_reg <= 1'b1;
            end
        end else if (wr && off == meb_pkg::OFF_MODE) begin
            mode_reg <= regWdata;
        end
    end

    // Read data stands in the cycle after the strobe.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (regRd && hit) begin
            case (off)
                meb_pkg::OFF_PA_DATA:   regRdata <= (paDir_reg & paData_reg)
                                                  | (~paDir_reg & paSync);
                meb_pkg::OFF_PB_DATA:   regRdata <= (pbDir_reg & pbData_reg)
                                                  | (~pbDir_reg & pbSync);
                meb_pkg::OFF_PA_DIR:    regRdata <= paDir_reg;
                meb_pkg::OFF_PB_DIR:    regRdata <= pbDir_reg;
                meb_pkg::OFF_PE_DATA:   regRdata <= (peDir_reg & peData_reg & 8'hfc)
                                                  | (~(peDir_reg & 8'hfc) & peSync);
                meb_pkg::OFF_PE_DIR:    regRdata <= peDir_reg;
                meb_pkg::OFF_PE_ASSIGN: regRdata <= port_e_pin_assignment_reg;
                meb_pkg::OFF_MODE:      regRdata <= mode_reg;
                meb_pkg::OFF_PULL:      regRdata <= pull_reg;
                meb_pkg::OFF_RDRIVE:    regRdata <= rdrive_reg;
                meb_pkg::OFF_BUS_CTL:   regRdata <= busCtl_reg;
                meb_pkg::OFF_IRQ_CTL:   regRdata <= irqCtl_reg;
                meb_pkg::OFF_PK_DATA:   regRdata <= (pkDir_reg & pkData_reg)
                                                  | (~pkDir_reg & pkSync);
                meb_pkg::OFF_PK_DIR:    regRdata <= pkDir_reg;
                default:                regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // External access sequencer: one low phase, then a high phase that a
    // slow access may stretch when stretching is selected.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= meb_pkg::ST_IDLE;
            stretch_reg <= 4'h0;
            {reqWrite_reg, reqLow_reg} <= 2'b00;
            reqAddr_reg <= 16'h0000;
            reqWdata_reg <= 16'h0000;
            busRdata <= 16'h0000;
            busDone <= 1'b0;
        end else begin
            busDone <= 1'b0;
            case (state_reg)
                meb_pkg::ST_IDLE: if (busReq && expanded) begin
                    state_reg <= meb_pkg::ST_LOW;
                    reqWrite_reg <= busWrite;
                    reqLow_reg <= busWide || busAddr[0];
                    reqAddr_reg <= busAddr;
                    reqWdata_reg <= busWdata;
                    stretch_reg <= (busSlow && busCtl_reg[meb_pkg::BCTL_STRETCH])
                                 ? meb_pkg::STRETCH_CYC : 4'h0;
                end
                meb_pkg::ST_LOW: state_reg <= meb_pkg::ST_HIGH;
                meb_pkg::ST_HIGH: begin
                    if (stretch_reg == 4'h0) begin
                        state_reg <= meb_pkg::ST_IDLE;
                        busRdata <= {paSync, pbSync};
                        busDone <= 1'b1;
                    end else begin
                        stretch_reg <= stretch_reg - 4'h1;
                    end
                end
                default: state_reg <= meb_pkg::ST_IDLE;
            endcase
        end
    end

    // Bus clock: port E data bit 4 when disabled, else free-running with visibility on, else one pulse per access.
    always_comb begin
        if (port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_CLK_DIS]) begin
            eclkNext = peData_reg[4];
        end else if (mode_reg[meb_pkg::MODE_INTERNAL_VISIBILITY]) begin
            eclkNext = ~peOut[4];
        end else begin
            eclkNext = (state_reg == meb_pkg::ST_HIGH);
        end
    end

    // Ports A and B: address in the low phase, write data in the high phase.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            {paOut, pbOut} <= 16'h0000;
            {paOeN, pbOeN} <= 16'hffff;
        end else if (periph) begin
            {paOut, pbOut} <= 16'h0000;
            {paOeN, pbOeN} <= 16'hffff;
        end else if (expanded) begin
            {paOut, pbOut} <= (state_reg == meb_pkg::ST_HIGH) ? reqWdata_reg
                                                               : reqAddr_reg;
            {paOeN, pbOeN} <= (state_reg == meb_pkg::ST_LOW
                           || (state_reg == meb_pkg::ST_HIGH && reqWrite_reg))
                           ? 16'h0000 : 16'hffff;
        end else begin
            {paOut, pbOut} <= {paData_reg, pbData_reg};
            {paOeN, pbOeN} <= ~{paDir_reg, pbDir_reg};
        end
    end

    // Port E function overlay; bits 1 and 0 are never driven.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            peOut <= 8'h00;
            peOeN <= 8'hff;
        end else begin
            peOut <= peData_reg;
            peOeN <= ~peDir_reg | 8'h03;
            if (!port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_CLK_DIS]) begin
                peOut[4] <= eclkNext;
                peOeN[4] <= 1'b0;
            end
            if (periph) begin
                peOeN[3:2] <= 2'b11;
            end else if (expanded) begin
                if (port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_LSTR_EN]) begin
                    peOut[3] <= ~((state_reg != meb_pkg::ST_IDLE) && reqLow_reg);
                    peOeN[3] <= 1'b0;
                end
                if (port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_RW_EN]) begin
                    peOut[2] <= ~((state_reg != meb_pkg::ST_IDLE) && reqWrite_reg);
                    peOeN[2] <= 1'b0;
                end
            end
        end
    end

    // Port K: chip selects on bits 7 and 6, expanded address below.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pkOut <= 8'h00;
            pkOeN <= 8'hff;
        end else begin
            pkOut <= pkData_reg;
            pkOeN <= ~pkDir_reg;
            if (expanded) begin
                pkOut[7:6] <= {~ecsHit, ~xcsHit};
                pkOeN[7:6] <= 2'b00;
                if (mode_reg[meb_pkg::MODE_EXP_EN]) begin
                    pkOut[5:0] <= expAddrHi;
                    pkOeN[5:0] <= 6'h00;
                end
            end
        end
    end

    // Pin-derived status seen by the core.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqReq <= 1'b0;
            irqPin1_reg <= 1'b1;
            nmiReqN <= 1'b1;
            lowTagN <= 1'b1;
            xferSize8 <= 1'b0;
            extWriteN <= 1'b1;
        end else begin
            irqPin1_reg <= peSync[1];
            nmiReqN <= peSync[0];
            xferSize8 <= periph && peSync[3];
            extWriteN <= ~periph || peSync[2];
            // A falling edge arriving with the acknowledge still sets the request.
            if (!irqCtl_reg[meb_pkg::IRQ_ENABLE]) begin
                irqReq <= 1'b0;
            end else if (!irqCtl_reg[meb_pkg::IRQ_EDGE]) begin
                irqReq <= !peSync[1];
            end else if (irqPin1_reg && !peSync[1]) begin
                irqReq <= 1'b1;
            end else if (irqAck) begin
                irqReq <= 1'b0;
            end
            lowTagN <= !(tagMode && tagOn && port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_LSTR_EN]
                      && peOut[4] && !eclkNext && !peSync[3]);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_reserved_zero: assert property (regRd && hit && (off[5:2] == 4'h1
        || off == 6'h0f) |=> regRdata == 8'h00)
        else $error("reserved offset read not zero");
    chk_dir_readback: assert property (regRd && hit && off == meb_pkg::OFF_PA_DIR
        |=> regRdata == $past(paDir_reg))
        else $error("port A direction readback wrong");
    chk_port_mux_read: assert property (regRd && hit && off == meb_pkg::OFF_PB_DATA
        |=> regRdata == (($past(pbDir_reg) & $past(pbData_reg))
                      | (~$past(pbDir_reg) & $past(pbSync))))
        else $error("port B read source wrong");
    chk_pe1_input: assert property (peOeN[1] && peOeN[0])
        else $error("input-only port E bit driven");
    chk_bus_timing_clock_free: assert property (mode_reg[meb_pkg::MODE_INTERNAL_VISIBILITY]
        && !port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_CLK_DIS] ##1 mode_reg[meb_pkg::MODE_INTERNAL_VISIBILITY]
        && !port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_CLK_DIS] |=> peOut[4] != $past(peOut[4]))
        else $error("free-running bus clock stalled");
    chk_bus_timing_clock_disable: assert property (port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_CLK_DIS]
        |=> peOut[4] == $past(peData_reg[4]))
        else $error("disabled bus clock not general purpose");
    chk_low_byte_strobe_n_lane: assert property (expanded && !periph
        && port_e_pin_assignment_reg[meb_pkg::PORT_E_PIN_ASSIGNMENT_LSTR_EN] && state_reg == meb_pkg::ST_LOW
        && reqLow_reg |=> !peOut[3] && !peOeN[3])
        else $error("low strobe not asserted for low lane");
    chk_periph_inputs: assert property (periph |=> peOeN[3] && peOeN[2])
        else $error("peripheral mode drives size or direction");
    chk_irq_level: assert property (irqCtl_reg[meb_pkg::IRQ_ENABLE]
        && !irqCtl_reg[meb_pkg::IRQ_EDGE] && !peSync[1] |=> irqReq)
        else $error("level interrupt not raised");
    chk_exp_addr: assert property (expanded && mode_reg[meb_pkg::MODE_EXP_EN]
        |=> pkOut[5:0] == $past(expAddrHi) && pkOeN[5:0] == 6'h00)
        else $error("expansion address not on port K");
    chk_access_len: assert property (state_reg == meb_pkg::ST_LOW
        |-> ##[2:4] busDone)
        else $error("external access did not finish in time");

    cov_write_access: cover property (busReq && busWrite && expanded ##[3:5] busDone);
    cov_stretched: cover property (state_reg == meb_pkg::ST_HIGH [*3]);
    cov_edge_irq: cover property (irqCtl_reg[meb_pkg::IRQ_EDGE] && $rose(irqReq));
    cov_low_tag: cover property (!lowTagN);
endmodule

/* include/meb_pkg.sv */
package meb_pkg;
    // Register offsets within the 64-byte block window.
    localparam logic [5:0] OFF_PA_DATA  = 6'h00;
    localparam logic [5:0] OFF_PB_DATA  = 6'h01;
    localparam logic [5:0] OFF_PA_DIR   = 6'h02;
    localparam logic [5:0] OFF_PB_DIR   = 6'h03;
    localparam logic [5:0] OFF_PE_DATA  = 6'h08;
    localparam logic [5:0] OFF_PE_DIR   = 6'h09;
    localparam logic [5:0] OFF_PE_ASSIGN = 6'h0a;
    localparam logic [5:0] OFF_MODE     = 6'h0b;
    localparam logic [5:0] OFF_PULL     = 6'h0c;
    localparam logic [5:0] OFF_RDRIVE   = 6'h0d;
    localparam logic [5:0] OFF_BUS_CTL  = 6'h0e;
    localparam logic [5:0] OFF_IRQ_CTL  = 6'h1e;
    localparam logic [5:0] OFF_PK_DATA  = 6'h32;
    localparam logic [5:0] OFF_PK_DIR   = 6'h33;
    localparam int         OFF_WIDTH    = 6;
    // Field positions.
    localparam int PORT_E_PIN_ASSIGNMENT_CLK_DIS  = 4;
    localparam int PORT_E_PIN_ASSIGNMENT_LSTR_EN  = 3;
    localparam int PORT_E_PIN_ASSIGNMENT_RW_EN    = 2;
    localparam int MODE_FLD_LO   = 5;
    localparam int MODE_INTERNAL_VISIBILITY     = 3;
    localparam int MODE_EXP_EN   = 0;
    localparam int BCTL_STRETCH  = 0;
    localparam int IRQ_EDGE      = 7;
    localparam int IRQ_ENABLE    = 6;
    // Reset values.
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_PIN_CONTROL = 8'h40;
    // Operating mode codes held in the upper three mode bits.
    localparam logic [2:0] MD_EMU_NARROW = 3'h1;
    localparam logic [2:0] MD_EMU_WIDE   = 3'h3;
    localparam logic [2:0] MD_PERIPH     = 3'h6;
    localparam logic [2:0] MD_NORM_WIDE  = 3'h7;
    // Extra high-phase cycles of a slow access.
    localparam logic [3:0] STRETCH_CYC = 4'h2;
    localparam logic [1:0] MODE_CAP_WAIT = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOW  = 3'b010,
        ST_HIGH = 3'b100
    } meb_state_t;
endpackage

/* tb/meb_ext_model.sv */
`timescale 1ns/10ps
// Pins and memory outside the port: a pin the block drives shows its value, a released pin
// shows what the memory or the tester drives on it.
module meb_ext_model (
    input  wire logic [7:0]  paOut,
    input  wire logic [7:0]  paOeN,
    input  wire logic [7:0]  pbOut,
    input  wire logic [7:0]  pbOeN,
    input  wire logic [7:0]  peOut,
    input  wire logic [7:0]  peOeN,
    input  wire logic [7:0]  pkOut,
    input  wire logic [7:0]  pkOeN,
    input  wire logic [15:0] memData,
    input  wire logic [7:0]  peDrive,
    input  wire logic [7:0]  pkDrive,
    output logic      [7:0]  paIn,
    output logic      [7:0]  pbIn,
    output logic      [7:0]  peIn,
    output logic      [7:0]  pkIn
);
    assign paIn = (~paOeN & paOut) | (paOeN & memData[15:8]);
    assign pbIn = (~pbOeN & pbOut) | (pbOeN & memData[7:0]);
    // In peripheral mode the tester drives size and direction on bits 3 and 2.
    assign peIn = (~peOeN & peOut) | (peOeN & peDrive);
    assign pkIn = (~pkOeN & pkOut) | (pkOeN & pkDrive);
endmodule

/* tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
    logic        mclk, rst, regWr, regRd, busReq, busSlow, xcsHit, ecsHit;
    logic        busDone, irqReq, nmiReqN, lowTagN, xferSize8, extWriteN;
    logic        busWrite, irqAck, rwLow;
    logic [15:0] regAddr, memData, busRdata;
    logic [7:0]  regWdata, regRdata, peDrive, d;
    logic [7:0]  paIn, paOut, paOeN, pbIn, pbOut, pbOeN, peIn, peOut, peOeN, pkIn, pkOut, pkOeN;
    logic [9:0]  blockBase, useBase;
    logic [2:0]  modePins;
    logic [5:0]  expAddrHi;
    logic [5:0]  rwOff [3] = '{meb_pkg::OFF_PA_DIR, meb_pkg::OFF_PB_DIR, meb_pkg::OFF_PK_DIR};
    logic [5:0]  rsvOff [6] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h0f, 6'h10};
    int          mismatches, compares, n;

    meb_port i_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .blockBase(blockBase),
        .modePins(modePins), .busReq(busReq), .busWrite(busWrite), .busWide(1'b1),
        .busSlow(busSlow), .busAddr(16'h1235), .busWdata(16'h0000), .busRdata(busRdata),
        .busDone(busDone), .tagOn(1'b0), .xcsHit(xcsHit), .ecsHit(ecsHit),
        .expAddrHi(expAddrHi), .irqAck(irqAck), .irqReq(irqReq), .nmiReqN(nmiReqN),
        .lowTagN(lowTagN), .xferSize8(xferSize8), .extWriteN(extWriteN), .paIn(paIn),
        .paOut(paOut), .paOeN(paOeN), .pbIn(pbIn), .pbOut(pbOut), .pbOeN(pbOeN),
        .peIn(peIn), .peOut(peOut), .peOeN(peOeN), .pkIn(pkIn), .pkOut(pkOut),
        .pkOeN(pkOeN));
    meb_ext_model i_ext (.paOut(paOut), .paOeN(paOeN), .pbOut(pbOut), .pbOeN(pbOeN),
        .peOut(peOut), .peOeN(peOeN), .pkOut(pkOut), .pkOeN(pkOeN), .memData(memData),
        .peDrive(peDrive), .pkDrive(8'h96), .paIn(paIn), .pbIn(pbIn), .peIn(peIn),
        .pkIn(pkIn));

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic doReset(input logic [2:0] m);
        rst <= 1'b1;
        modePins <= m;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic wr(input logic [5:0] off, input logic [7:0] v);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= {useBase, off};
        regWdata <= v;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] off);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= {useBase, off};
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    // Counts cycles from the edge that takes the request to the done pulse.
    task automatic busAcc(input logic slow);
        rwLow = 1'b0;
        @(posedge mclk);
        busReq <= 1'b1;
        busSlow <= slow;
        @(posedge mclk);
        busReq <= 1'b0;
        for (n = 1; n <= 20; n++) begin
            @(posedge mclk);
            #1;
            if (peOeN[2] === 1'b0 && peOut[2] === 1'b0) rwLow = 1'b1;
            if (busDone === 1'b1) break;
        end
        if (n > 20) begin
            mismatches++;
            summarize();
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1; regWr = 1'b0; regRd = 1'b0; busReq = 1'b0; busSlow = 1'b0;
        xcsHit = 1'b0; ecsHit = 1'b0; regAddr = 16'h0000; regWdata = 8'h00;
        blockBase = 10'h015; useBase = 10'h015; modePins = 3'h0; expAddrHi = 6'h2d;
        memData = 16'hc33c; peDrive = 8'hff; mismatches = 0; compares = 0;
        busWrite = 1'b0;
        irqAck = 1'b0;
        rwLow = 1'b0;
        doReset(3'h0);
        rd(meb_pkg::OFF_IRQ_CTL); `CHK("irq_ctl_rst", meb_pkg::RST_INTERRUPT_PIN_CONTROL, d)
        for (int i = 0; i < 3; i++) begin
            rd(rwOff[i]); `CHK("dir_rst", meb_pkg::RST_BYTE, d)
            wr(rwOff[i], 8'h5a ^ 8'(i));
            rd(rwOff[i]); `CHK("dir_rw", 8'h5a ^ 8'(i), d)
        end
        for (int i = 0; i < 6; i++) begin
            wr(rsvOff[i], 8'hff);
            rd(rsvOff[i]); `CHK("reserved", 8'h00, d)
        end
        useBase = blockBase ^ 10'h001;
        wr(meb_pkg::OFF_PA_DIR, 8'hff);
        rd(meb_pkg::OFF_PA_DIR); `CHK("other_base", 8'h00, d)
        useBase = blockBase;
        rd(meb_pkg::OFF_PA_DIR); `CHK("base_kept", 8'h5a, d)
        wr(meb_pkg::OFF_PA_DIR, 8'hf0);
        wr(meb_pkg::OFF_PA_DATA, 8'ha5);
        rd(meb_pkg::OFF_PA_DATA); `CHK("pa_mixed", 8'ha3, d)
        peDrive <= 8'hfd;
        repeat (5) @(posedge mclk);
        rd(meb_pkg::OFF_PE_DATA); `CHK("pe_pins", 2'b01, d[1:0])
        `CHK("irq_level", 1'b1, irqReq)
        `CHK("nmi_idle", 1'b1, nmiReqN)
        peDrive <= 8'hfe;
        repeat (5) @(posedge mclk);
        `CHK("irq_gone", 1'b0, irqReq)
        `CHK("nmi_low", 1'b0, nmiReqN)
        wr(meb_pkg::OFF_IRQ_CTL, 8'hc0);
        peDrive <= 8'hfc;
        repeat (5) @(posedge mclk);
        `CHK("irq_edge", 1'b1, irqReq)
        irqAck <= 1'b1;
        @(posedge mclk);
        irqAck <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("irq_acked", 1'b0, irqReq)
        peDrive <= 8'hff;
        doReset(meb_pkg::MD_NORM_WIDE);
        rd(meb_pkg::OFF_MODE); `CHK("mode_cap", meb_pkg::MD_NORM_WIDE, d[7:5])
        xcsHit <= 1'b1;
        repeat (4) @(posedge mclk);
        `CHK("chip_sel", 2'b10, pkOut[7:6])
        memData <= 16'hc3a5;
        busAcc(1'b0); `CHK("fast_len", 2, n)
        `CHK("bus_rdata", 16'hc3a5, busRdata)
        `CHK("rw_out", 1'b1, extWriteN)
        wr(meb_pkg::OFF_BUS_CTL, 8'h01);
        busAcc(1'b1); `CHK("slow_len", 2 + int'(meb_pkg::STRETCH_CYC), n)
        busAcc(1'b0); `CHK("fast_again", 2, n)
        wr(meb_pkg::OFF_PE_ASSIGN, 8'h0c);
        busWrite <= 1'b1;
        busAcc(1'b0); `CHK("rw_pin_wr", 1'b1, rwLow)
        busWrite <= 1'b0;
        busAcc(1'b0); `CHK("rw_pin_rd", 1'b0, rwLow)
        wr(meb_pkg::OFF_MODE, 8'he9);
        repeat (2) @(posedge mclk);
        `CHK("exp_addr", 6'h2d, pkOut[5:0])
        #1 d[0] = peOut[4];
        @(posedge mclk);
        #1 `CHK("bus_timing_clock_free", ~d[0], peOut[4])
        // Peripheral mode: the tester selects a 16-bit write, then an 8-bit read.
        peDrive <= 8'hf3;
        doReset(meb_pkg::MD_PERIPH);
        `CHK("size16", 1'b0, xferSize8)
        `CHK("rw_in_wr", 1'b0, extWriteN)
        peDrive <= 8'hff;
        repeat (5) @(posedge mclk);
        `CHK("size8", 1'b1, xferSize8)
        `CHK("rw_in_rd", 1'b1, extWriteN)
        summarize();
    end
endmodule
